// *** common/ladder_tc_pkg.sv ***
// Constants and types shared by the ladder timer/counter bank
package ladder_tc_pkg;
  localparam int NUM_TIMERS = 64;
  localparam int NUM_COUNTERS = 64;
  localparam int VAL_W = 16;
  localparam int WORD_BITS = 16;
  localparam int NUM_SEQ = 8;
  localparam int SEQ_STEPS = 32;
  localparam int ADDR_W = 12;
  // Byte offsets of the register regions, one 32-bit word per entry
  localparam logic [ADDR_W-1:0] TIMER_PRESENT_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] TIMER_PRESET_OFS = 12'h100;
  localparam logic [ADDR_W-1:0] COUNTER_PRESENT_OFS = 12'h200;
  localparam logic [ADDR_W-1:0] COUNTER_PRESET_OFS = 12'h300;
  localparam logic [ADDR_W-1:0] CONTACT_WORDS_OFS = 12'h400;
  localparam logic [5:0] COUNTER_WORDS_IDX = 6'h04;
  localparam logic [5:0] CONTACT_WORDS_END = 6'h08;
  localparam logic [VAL_W-1:0] VALUE_RST = 16'h0000;
  // Time base: tick period and clock period in ns
  localparam longint TICK_TIME_NS = 100000000;
  localparam longint CLK_PERIOD_NS = 40;
  localparam int TICK_CYCLES_DEF = int'(TICK_TIME_NS / CLK_PERIOD_NS);
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_NONE = 32'h00000000;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:2] word;
  } bus_pend_type;
endpackage

// *** src/ladder_timer_counter_bank.sv ***
// Bank of on-delay timers and down-counters behind an AHB-Lite slave
//
// Functional notes
// - Energized timer keeps contact open until its preset delay elapses.
// - Expired timer contact stays closed while the coil stays energized.
// - Coil turning off opens the timer contact at once.
// - Coil off before expiry resets the timer; no contact that activation.
// - Re-energized timer restarts from full preset, not partial count.
// - First counter coil energize after reset loads preset minus one.
// - Each later coil rising edge decrements the count by one, until the count reaches zero.
// - Coil held energized does not decrement the counter.
// - Count reaching zero turns the counter contact on.
// - Counter contact stays on regardless of later coil state.
// - Only counter clear turns contact off and unloads counter.
// - 64 timers and 64 counters, present values readable/writable by index.
// - Timer and counter contacts packed into separate 16-bit word arrays.
// - Each timer and counter preset writable at run time.
// - Writing non-zero timer present value starts it for that many ticks.
// - Present value writes take effect immediately.
// - Sequencer step counter held and every step decoded.
// - Eight sequencers reuse counters zero to seven, 32 steps each.
`timescale 1ns/10ps
module ladder_timer_counter_bank
  import ladder_tc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Coils from ladder evaluation, same clock
  input wire logic [NUM_TIMERS-1:0] timer_coil,
  input wire logic [NUM_COUNTERS-1:0] counter_coil,
  input wire logic [NUM_COUNTERS-1:0] counter_clear_function,
  // Contacts and sequencer steps
  output logic [NUM_TIMERS-1:0] timer_contact,
  output logic [NUM_COUNTERS-1:0] counter_contact,
  output logic [NUM_SEQ*SEQ_STEPS-1:0] seq_step
);

  localparam int TW = $clog2(TICK_CYCLES);

  logic [VAL_W-1:0] tmr_pv_r [NUM_TIMERS];
  logic [VAL_W-1:0] tmr_pre_r [NUM_TIMERS];
  logic [VAL_W-1:0] cnt_pv_r [NUM_COUNTERS];
  logic [VAL_W-1:0] cnt_pre_r [NUM_COUNTERS];
  logic [NUM_TIMERS-1:0] tmr_run_r;
  logic [NUM_TIMERS-1:0] tmr_done_r;
  logic [NUM_TIMERS-1:0] tcoil_d_r;
  logic [NUM_COUNTERS-1:0] cnt_load_r;
  logic [NUM_COUNTERS-1:0] cnt_hit_r;
  logic [NUM_COUNTERS-1:0] ccoil_d_r;
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;
  bus_pend_type pend_r;
  logic [31:0] hrdata_r;

  // Time base
  wire tick_wrap = (tick_cnt_r == TW'(TICK_CYCLES - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + TW'(1);
      tick_r <= tick_wrap;
    end
  end

  // Bus decode; slave never stalls, so writes land in the data phase
  wire addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire [ADDR_W-1:2] a_word = haddr[ADDR_W-1:2];
  wire [3:0] p_reg = pend_r.word[ADDR_W-1:8];
  wire [5:0] p_idx = pend_r.word[7:2];
  wire [3:0] a_reg = a_word[ADDR_W-1:8];
  wire [5:0] a_idx = a_word[7:2];
  wire wr_ok = pend_r.valid;
  wire tpv_sel = wr_ok && (p_reg == TIMER_PRESENT_OFS[ADDR_W-1:8]);
  wire tpre_sel = wr_ok && (p_reg == TIMER_PRESET_OFS[ADDR_W-1:8]);
  wire cpv_sel = wr_ok && (p_reg == COUNTER_PRESENT_OFS[ADDR_W-1:8]);
  wire cpre_sel = wr_ok && (p_reg == COUNTER_PRESET_OFS[ADDR_W-1:8]);
  wire [VAL_W-1:0] wval = hwdata[VAL_W-1:0];
  wire [NUM_TIMERS-1:0] tpv_we;
  wire [NUM_COUNTERS-1:0] cpv_we;
  wire bus_hit_upper = (haddr[31:ADDR_W] == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= '0;
    end else begin
      pend_r.valid <= addr_ok && hwrite && bus_hit_upper;
      pend_r.word <= a_word;
    end
  end

  // Contact words, 16 bits each, timers then counters
  wire [WORD_BITS-1:0] tword = timer_contact[a_idx[1:0]*WORD_BITS +: WORD_BITS];
  wire [WORD_BITS-1:0] cword = counter_contact[a_idx[1:0]*WORD_BITS +: WORD_BITS];
  wire [VAL_W-1:0] rd_val =
    (a_reg == TIMER_PRESENT_OFS[ADDR_W-1:8]) ? tmr_pv_r[a_idx] :
    (a_reg == TIMER_PRESET_OFS[ADDR_W-1:8]) ? tmr_pre_r[a_idx] :
    (a_reg == COUNTER_PRESENT_OFS[ADDR_W-1:8]) ? cnt_pv_r[a_idx] :
    (a_reg == COUNTER_PRESET_OFS[ADDR_W-1:8]) ? cnt_pre_r[a_idx] :
    (a_reg != CONTACT_WORDS_OFS[ADDR_W-1:8]) ? VALUE_RST :
    (a_idx < COUNTER_WORDS_IDX) ? tword :
    (a_idx < CONTACT_WORDS_END) ? cword : VALUE_RST;
  wire wr_region = (a_reg < CONTACT_WORDS_OFS[ADDR_W-1:8]);
  // Read right after a write to the same word sees the new value
  wire fwd = wr_ok && (pend_r.word == a_word) && wr_region;
  wire [31:0] rd_word = !bus_hit_upper ? RDATA_NONE :
    fwd ? {16'h0000, wval} : {16'h0000, rd_val};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= RDATA_NONE;
    end else if (addr_ok && !hwrite) begin
      hrdata_r <= rd_word;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign timer_contact = tmr_done_r;
  assign counter_contact = cnt_hit_r;

  genvar gi;
  // Timers
  for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
    wire rise = timer_coil[gi] && !tcoil_d_r[gi];
    wire fall = !timer_coil[gi] && tcoil_d_r[gi];
    wire pv_last = (tmr_pv_r[gi] == 16'h0001);
    assign tpv_we[gi] = tpv_sel && (p_idx == 6'(gi));
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        tmr_pre_r[gi] <= VALUE_RST;
      end else if (tpre_sel && (p_idx == 6'(gi))) begin
        tmr_pre_r[gi] <= wval;
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        tmr_pv_r[gi] <= VALUE_RST;
        tmr_run_r[gi] <= 1'b0;
        tmr_done_r[gi] <= 1'b0;
        tcoil_d_r[gi] <= 1'b0;
      end else begin
        tcoil_d_r[gi] <= timer_coil[gi];
        if (tpv_we[gi]) begin
          tmr_pv_r[gi] <= wval;
          tmr_run_r[gi] <= (wval != VALUE_RST);
          tmr_done_r[gi] <= 1'b0;
        end else if (rise) begin
          tmr_pv_r[gi] <= tmr_pre_r[gi];
          tmr_run_r[gi] <= (tmr_pre_r[gi] != VALUE_RST);
          tmr_done_r[gi] <= (tmr_pre_r[gi] == VALUE_RST);
        end else if (fall) begin
          tmr_pv_r[gi] <= VALUE_RST;
          tmr_run_r[gi] <= 1'b0;
          tmr_done_r[gi] <= 1'b0;
        end else if (tick_r && tmr_run_r[gi]) begin
          tmr_pv_r[gi] <= tmr_pv_r[gi] - 16'h0001;
          tmr_run_r[gi] <= !pv_last;
          tmr_done_r[gi] <= pv_last;
        end
      end
    end
  end

  // Counters
  for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_cnt
    wire rise = counter_coil[gi] && !ccoil_d_r[gi];
    wire clr = counter_clear_function[gi];
    logic [VAL_W-1:0] pv_nxt;
    logic load_nxt;
    assign cpv_we[gi] = cpv_sel && (p_idx == 6'(gi));
    always_comb begin
      pv_nxt = cnt_pv_r[gi];
      load_nxt = cnt_load_r[gi];
      if (clr) begin
        load_nxt = 1'b0;
      end else if (cpv_we[gi]) begin
        pv_nxt = wval;
        load_nxt = 1'b1;
      end else if (rise && !cnt_load_r[gi]) begin
        pv_nxt = cnt_pre_r[gi] - 16'h0001;
        load_nxt = 1'b1;
      end else if (rise && (cnt_pv_r[gi] != VALUE_RST)) begin
        pv_nxt = cnt_pv_r[gi] - 16'h0001;
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cnt_pre_r[gi] <= VALUE_RST;
      end else if (cpre_sel && (p_idx == 6'(gi))) begin
        cnt_pre_r[gi] <= wval;
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cnt_pv_r[gi] <= VALUE_RST;
        cnt_load_r[gi] <= 1'b0;
        cnt_hit_r[gi] <= 1'b0;
        ccoil_d_r[gi] <= 1'b0;
      end else begin
        ccoil_d_r[gi] <= counter_coil[gi];
        cnt_pv_r[gi] <= pv_nxt;
        cnt_load_r[gi] <= load_nxt;
        // Latches on, only clear drops it
        cnt_hit_r[gi] <= (cnt_hit_r[gi] && !clr) ||
          (load_nxt && (pv_nxt == VALUE_RST));
      end
    end
  end

  // Sequencer steps; inactive (unloaded) counter shows no step
  for (gi = 0; gi < NUM_SEQ * SEQ_STEPS; gi++) begin : g_seq
    assign seq_step[gi] = cnt_load_r[gi / SEQ_STEPS] &&
      (cnt_pv_r[gi / SEQ_STEPS] == 16'(gi % SEQ_STEPS));
  end

  // Checks sit on the entries that scenarios really drive
  localparam int CT = 3;
  localparam int CS = 7;
  localparam int CC = 5;
  localparam int CW = 2;

  // Timer checks
  a_timer_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tmr_pv_r[CT] != VALUE_RST) |-> !timer_contact[CT])
    else $error("timer contact closed before delay ran out");
  a_timer_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_contact[CT] && timer_coil[CT] && tcoil_d_r[CT] && !tpv_we[CT] |=> timer_contact[CT])
    else $error("timer contact dropped while coil on");
  a_timer_coil_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(timer_coil[CT]) && !tpv_we[CT] |=> !timer_contact[CT] && tmr_pv_r[CT] == VALUE_RST)
    else $error("timer contact not opened at coil off");
  a_timer_abort: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tmr_run_r[CT] && $fell(timer_coil[CT]) && !tpv_we[CT] |=> !timer_contact[CT] && !tmr_run_r[CT])
    else $error("aborted timer still running");
  a_timer_restart: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(timer_coil[CT]) && !tpv_we[CT] |=> tmr_pv_r[CT] == $past(tmr_pre_r[CT]))
    else $error("timer did not restart from preset");
  a_timer_soft: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tpv_we[CS] && wval != VALUE_RST |=> tmr_pv_r[CS] == $past(wval) && tmr_run_r[CS])
    else $error("timer write did not start timer");
  a_timer_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tpv_we[CS] |=> tmr_pv_r[CS] == $past(wval) && !timer_contact[CS])
    else $error("timer present write not immediate");
  a_tick_single: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (TICK_CYCLES > 1) && tick_r |=> !tick_r)
    else $error("tick longer than one cycle");
  a_reg_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tpre_sel && (p_idx == 6'(CT)) |=> tmr_pre_r[CT] == $past(wval))
    else $error("timer preset write lost");

  // Counter checks
  a_ctr_first: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(counter_coil[CC]) && !cnt_load_r[CC] && !counter_clear_function[CC] && !cpv_we[CC]
    |=> cnt_pv_r[CC] == $past(cnt_pre_r[CC]) - 16'h0001)
    else $error("counter first load wrong");
  a_ctr_decr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(counter_coil[CC]) && cnt_load_r[CC] && cnt_pv_r[CC] != VALUE_RST &&
    !counter_clear_function[CC] && !cpv_we[CC] |=> cnt_pv_r[CC] == $past(cnt_pv_r[CC]) - 16'h0001)
    else $error("counter did not decrement by one");
  a_ctr_steady: assert property (
    @(posedge hclk) disable iff (!hresetn)
    counter_coil[CC] && $past(counter_coil[CC]) && !cpv_we[CC] |=> $stable(cnt_pv_r[CC]))
    else $error("counter moved while coil held");
  a_ctr_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cnt_load_r[CC] && cnt_pv_r[CC] == VALUE_RST |-> counter_contact[CC])
    else $error("counter at zero without contact");
  a_ctr_latch: assert property (
    @(posedge hclk) disable iff (!hresetn)
    counter_contact[CC] && !counter_clear_function[CC] |=> counter_contact[CC])
    else $error("counter contact dropped without clear");
  a_ctr_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    counter_clear_function[CC] |=> !counter_contact[CC] && !cnt_load_r[CC])
    else $error("counter clear ineffective");
  a_ctr_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cpv_we[CW] && !counter_clear_function[CW] |=> cnt_pv_r[CW] == $past(wval) && cnt_load_r[CW])
    else $error("counter present write not immediate");

  // Sequencer, bus and reset checks
  a_seq_decode: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cnt_load_r[CC] && cnt_pv_r[CC] < 16'(SEQ_STEPS) |-> seq_step[CC*SEQ_STEPS + int'(cnt_pv_r[CC])])
    else $error("sequencer step not decoded");
  a_seq_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !cnt_load_r[CC] |-> seq_step[CC*SEQ_STEPS +: SEQ_STEPS] == '0)
    else $error("idle sequencer shows a step");
  a_bus_okay: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus slave stalled or errored");
  a_contact_word: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && bus_hit_upper && a_reg == CONTACT_WORDS_OFS[ADDR_W-1:8] && a_idx == 6'h00
    |=> hrdata == {16'h0000, $past(timer_contact[WORD_BITS-1:0])})
    else $error("timer contact word wrong");
  a_reset_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> !timer_contact[CT] && !counter_contact[CC] && !cnt_load_r[CC])
    else $error("state not cleared by reset");

  // Scenario covers
  c_timer_expire: cover property (@(posedge hclk) disable iff (!hresetn)
    timer_coil[CT] ##1 $rose(timer_contact[CT]));
  c_timer_abort: cover property (@(posedge hclk) disable iff (!hresetn)
    tmr_run_r[CT] && $fell(timer_coil[CT]));
  c_timer_soft: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(timer_contact[CS]));
  c_ctr_hit: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(counter_contact[CC]));
  c_bus_read: cover property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite ##1 addr_ok && hwrite);
endmodule

// *** tb/ladder_timer_counter_bank_tb.sv ***
// Self-checking testbench for the ladder timer/counter bank
`timescale 1ns/10ps
module ladder_timer_counter_bank_tb;
  import ladder_tc_pkg::*;
  // Short tick keeps the run brief
  localparam int T = 10;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [63:0] timer_coil, counter_coil, counter_clear_function, timer_contact, counter_contact;
  logic [255:0] seq_step;
  int num_errors, checks, n;
  // Single slave, so its readiness is the bus readiness
  assign hready = hreadyout;
  ladder_timer_counter_bank #(.TICK_CYCLES(T)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_coil(timer_coil), .counter_coil(counter_coil),
    .counter_clear_function(counter_clear_function), .timer_contact(timer_contact),
    .counter_contact(counter_contact), .seq_step(seq_step));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Bounded wait for a high hready at a rising edge
  task automatic rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 16) begin
        num_errors++;
        wrap_up();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= a;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
    chk("hresp", hresp, 64'h0);
    chk("hreadyout", hreadyout, 64'h1);
  endtask
  task automatic meas(input int i, output int c);
    c = 0;
    while (timer_contact[i] !== 1'b1) begin
      @(negedge hclk);
      c++;
      if (c > 200) begin
        num_errors++;
        wrap_up();
      end
    end
  endtask
  task automatic pulse(input int i);
    @(posedge hclk);
    counter_coil[i] <= 1'b1;
    @(posedge hclk);
    counter_coil[i] <= 1'b0;
    @(posedge hclk);
  endtask
  initial begin
    repeat (50000) @(posedge hclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; timer_coil = 64'h0; counter_coil = 64'h0;
    counter_clear_function = 64'h0; num_errors = 0; checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h000, 32'h0); chk("timer_pv0", rd, 64'h0);
    bus(1'b0, 32'h41C, 32'h0); chk("ctr_word3", rd, 64'h0);
    bus(1'b1, 32'h400, 32'hFFFF); bus(1'b0, 32'h400, 32'h0); chk("ro_word", rd, 64'h0);
    bus(1'b0, 32'h800, 32'h0); chk("unmapped", rd, 64'h0);
    $display("test reset_and_map done");
    bus(1'b1, 32'h10C, 32'h5); bus(1'b0, 32'h10C, 32'h0); chk("tpreset3", rd, 64'h5);
    @(posedge hclk) timer_coil[3] <= 1'b1;
    meas(3, n); chk("delay", 64'(n >= 4*T && n <= 5*T+3), 64'h1);
    repeat (30) @(negedge hclk);
    chk("held", timer_contact[3], 64'h1);
    bus(1'b0, 32'h400, 32'h0); chk("tword0", rd, 64'h8);
    timer_coil[3] <= 1'b0;
    repeat (2) @(negedge hclk);
    chk("opens", timer_contact[3], 64'h0);
    @(posedge hclk) timer_coil[3] <= 1'b1;
    repeat (25) @(posedge hclk);
    timer_coil[3] <= 1'b0;
    repeat (3) @(negedge hclk);
    chk("abort", timer_contact[3], 64'h0);
    // A resumed count would expire well inside the lower bound
    @(posedge hclk) timer_coil[3] <= 1'b1;
    meas(3, n); chk("restart", 64'(n >= 4*T && n <= 5*T+3), 64'h1);
    @(posedge hclk) timer_coil[3] <= 1'b0;
    bus(1'b1, 32'h01C, 32'h2);
    meas(7, n); chk("pv_start", 64'(n >= T && n <= 2*T+3), 64'h1);
    bus(1'b1, 32'h01C, 32'h0); @(negedge hclk); chk("pv_stop", timer_contact[7], 64'h0);
    $display("test timers done");
    bus(1'b1, 32'h314, 32'h3);
    pulse(5); bus(1'b0, 32'h214, 32'h0); chk("first_load", rd, 64'h2);
    @(posedge hclk) counter_coil[5] <= 1'b1;
    repeat (20) @(posedge hclk);
    bus(1'b0, 32'h214, 32'h0); chk("held_coil", rd, 64'h1);
    counter_coil[5] <= 1'b0;
    pulse(5); @(negedge hclk); chk("ctr_on", counter_contact[5], 64'h1);
    bus(1'b0, 32'h410, 32'h0); chk("cword0", rd, 64'h20);
    pulse(5); bus(1'b0, 32'h214, 32'h0); chk("stays0", rd, 64'h0);
    chk("still_on", counter_contact[5], 64'h1);
    @(posedge hclk) counter_clear_function[5] <= 1'b1;
    @(posedge hclk) counter_clear_function[5] <= 1'b0;
    @(negedge hclk); chk("cleared", counter_contact[5], 64'h0);
    pulse(5); bus(1'b0, 32'h214, 32'h0); chk("reload", rd, 64'h2);
    $display("test counters done");
    bus(1'b1, 32'h2FC, 32'h1234); bus(1'b0, 32'h2FC, 32'h0); chk("ctr63", rd, 64'h1234);
    bus(1'b1, 32'h208, 32'h4); @(negedge hclk);
    chk("seq_step", seq_step[95:64], 64'h10);
    @(posedge hclk) hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h2FC, 32'h0); chk("rst_pv", rd, 64'h0);
    chk("rst_seq", seq_step[95:64], 64'h0);
    $display("test direct_and_reset done");
    wrap_up();
  end
endmodule
